// *** rtl/sasp_pkg.sv ***
package sasp_pkg;

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
localparam logic [7:0] ADR_CTRL = 8'h00; // Control word
localparam logic [7:0] ADR_STAT = 8'h04; // Status low
localparam logic [7:0] ADR_MASK = 8'h08; // Interrupt masks
localparam logic [7:0] ADR_DATA = 8'h0C; // Data window
localparam logic [7:0] ADR_ELM = 8'h10; // Element counts

// ---------------------------------------------
// Status bit positions (mask uses the same)
// ---------------------------------------------
localparam int ST_RBF = 0;
localparam int ST_TBF = 1;
localparam int ST_SPARE = 2; // Always zero
localparam int ST_TBE = 3;
localparam int ST_RBE = 4;
localparam int ST_SHIFT_REGISTER_EMPTY = 5;
localparam int ST_ROV = 6;
localparam int ST_TUR = 7;
localparam int ST_BUSY = 8;
localparam int ST_FERR = 9;
localparam int ST_RWM = 10;
localparam int ST_TWM = 11;
localparam int EL_TX = 0; // Element count fields
localparam int EL_RX = 8;

// Interrupt groups over the status bits
localparam logic [15:0] RX_GRP = 16'h0451;
localparam logic [15:0] TX_GRP = 16'h088A;
localparam logic [15:0] GEN_GRP = 16'h0320;

// ---------------------------------------------
// Buffer sizing and watermarks
// ---------------------------------------------
localparam logic [5:0] LIM_STD = 6'h01; // Single buffer
localparam logic [5:0] LIM_ENH = 6'h3F; // Count 111111
localparam logic [5:0] RX_WM = 6'h20;
localparam logic [5:0] TX_WM = 6'h04;
localparam logic [4:0] LEN_MIN = 5'h01; // Two bits
localparam logic SS_RST = 1'b1; // Select idles high

// Pin usage and audio format codes
localparam logic [1:0] PINS_4 = 2'h0;
localparam logic [1:0] PINS_3 = 2'h1;
localparam logic [1:0] PINS_2 = 2'h2;
localparam logic [1:0] FMT_PCM = 2'h3;

typedef enum logic [2:0] {
    ENG_IDLE = 3'h1,
    ENG_SHIFT = 3'h2,
    ENG_HALT = 3'h4
} sasp_eng_e;

// Control register, 23 bits from bit 22 downward
typedef struct packed {
    logic [7:0] div; // Half period minus one
    logic [4:0] len; // Word bits minus one
    logic ignore_underrun;
    logic [1:0] pins;
    logic [1:0] fmt;
    logic aud;
    logic frm;
    logic enh;
    logic mst;
    logic en;
} sasp_ctrl_s;

typedef struct packed {
    sasp_ctrl_s ctrl;
    logic [15:0] mask;
    logic [63:0][31:0] txMem;
    logic [63:0][31:0] rxMem;
    logic [5:0] txWp, txRp, txCnt;
    logic [5:0] rxWp, rxRp, rxCnt;
    logic [31:0] txSr, rxSr;
    logic [4:0] bitCnt;
    logic [7:0] divCnt;
    sasp_eng_e eng;
    logic sck, ss, sdo;
    logic [1:0] sckS, ssS, sdiS;
    logic sckD, ssD;
    logic rov, tur, ferr;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] irq;
} sasp_state_s;

endpackage

// *** rtl/sasp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// How it works
// - single buffer or deep FIFO, selectable
// - word length from 2 to 32 bits
// - framed operation as master or slave
// - four audio formats supported
// - audio master starts each word with or without data
// - audio master makes shift and channel clocks
// - audio slave follows a third-party master
// - data in, data out, clock, select pins
// - 3-pin drops select, 2-pin drops data out
// - receive flag from masked receive conditions
// - transmit flag from masked transmit conditions
// - general flag from masked error/busy/empty
// - transmit empty at bit 3
// - transmit full at bit 1
// - receive full at bit 0
// - status bit 2 reads zero
// - underrun cleared while disabled
// - ignore-underrun gives live, non-halting flag
module sasp_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutOe,
    input wire logic shiftClockIn,
    output logic shiftClockOut,
    output logic shiftClockOe,
    input wire logic selectIn,
    output logic selectOut,
    output logic selectOe,
    output logic receiveIrqFlag,
    output logic transmitIrqFlag,
    output logic generalIrqFlag
);

    sasp_pkg::sasp_state_s s; // Whole state
    sasp_pkg::sasp_state_s next_s; // Its next value
    logic req; // New bus request
    logic [15:0] stat; // Assembled status
    logic [5:0] txLim, rxLim; // Buffer depth in use
    logic [4:0] len; // Bits per word minus one
    logic txPush, txPop, rxPush, rxPop;
    logic tick, doRise, doFall, slvRise, slvFall;
    logic fsEdge, start, under, pulse;

    // Byte-lane merge for writable words
    function automatic logic [31:0] sasp_merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ---------------------------------------------
    // Status and derived terms
    // ---------------------------------------------
    always_comb begin
        txLim = s.ctrl.enh ? sasp_pkg::LIM_ENH : sasp_pkg::LIM_STD;
        rxLim = txLim;
        len = (s.ctrl.len < sasp_pkg::LEN_MIN) ? sasp_pkg::LEN_MIN : s.ctrl.len;
        stat = 16'h0000; // Spare bit stays zero
        stat[sasp_pkg::ST_RBF] = s.rxCnt == rxLim;
        stat[sasp_pkg::ST_TBF] = s.txCnt == txLim;
        stat[sasp_pkg::ST_TBE] = s.txCnt == 6'h00;
        stat[sasp_pkg::ST_RBE] = s.rxCnt == 6'h00;
        stat[sasp_pkg::ST_SHIFT_REGISTER_EMPTY] = s.eng == sasp_pkg::ENG_IDLE;
        stat[sasp_pkg::ST_ROV] = s.rov;
        stat[sasp_pkg::ST_TUR] = s.tur;
        stat[sasp_pkg::ST_BUSY] = s.eng != sasp_pkg::ENG_IDLE;
        stat[sasp_pkg::ST_FERR] = s.ferr;
        stat[sasp_pkg::ST_RWM] = s.rxCnt >= sasp_pkg::RX_WM;
        stat[sasp_pkg::ST_TWM] = s.txCnt <= sasp_pkg::TX_WM;
    end

    assign req = wb_cyc_i && wb_stb_i && !s.ack;
    // Master edges come from the divider, slave edges from the pin
    // Limitation: a master needs div of 2 or more, since data in crosses two flops
    assign tick = s.divCnt == s.ctrl.div;
    assign slvRise = s.sckS[1] && !s.sckD;
    assign slvFall = !s.sckS[1] && s.sckD;
    assign fsEdge = s.ssS[1] ^ s.ssD;
    assign doRise = s.ctrl.mst ? (tick && !s.sck) : slvRise;
    assign doFall = s.ctrl.mst ? (tick && s.sck) : slvFall;
    // Framed and PCM use a one-bit pulse, other audio a level
    assign pulse = s.ctrl.frm || (s.ctrl.aud && s.ctrl.fmt == sasp_pkg::FMT_PCM);

    // ---------------------------------------------
    // Next-state logic
    // ---------------------------------------------
    always_comb begin
        next_s = s;
        txPush = 1'b0;
        txPop = 1'b0;
        rxPush = 1'b0;
        rxPop = 1'b0;
        under = 1'b0;
        start = 1'b0;
        next_s.ack = req;
        // Two-flop synchronisers, third stage for edges
        next_s.sckS = {s.sckS[0], shiftClockIn};
        next_s.ssS = {s.ssS[0], selectIn};
        next_s.sdiS = {s.sdiS[0], serialDataIn};
        next_s.sckD = s.sckS[1];
        next_s.ssD = s.ssS[1];
        // Interrupt flags are masked status ORs
        next_s.irq[0] = |(stat & s.mask & sasp_pkg::RX_GRP);
        next_s.irq[1] = |(stat & s.mask & sasp_pkg::TX_GRP);
        next_s.irq[2] = |(stat & s.mask & sasp_pkg::GEN_GRP);

        // Bus side first, so engine sets below win over clears
        if (req) begin
            next_s.rdat = 32'h0000_0000;
            case (wb_adr_i)
                sasp_pkg::ADR_CTRL: begin
                    if (wb_we_i) begin
                        next_s.ctrl = 23'(sasp_merge({9'h000, s.ctrl}, wb_dat_i, wb_sel_i));
                    end else begin
                        next_s.rdat = {9'h000, s.ctrl};
                    end
                end
                sasp_pkg::ADR_STAT: begin
                    if (wb_we_i) begin
                        // Write one to clear sticky errors
                        if (wb_dat_i[sasp_pkg::ST_ROV]) next_s.rov = 1'b0;
                        if (wb_dat_i[sasp_pkg::ST_TUR]) next_s.tur = 1'b0;
                        if (wb_dat_i[sasp_pkg::ST_FERR]) next_s.ferr = 1'b0;
                    end else begin
                        next_s.rdat = {16'h0000, stat};
                    end
                end
                sasp_pkg::ADR_MASK: begin
                    if (wb_we_i) begin
                        next_s.mask = 16'(sasp_merge({16'h0000, s.mask}, wb_dat_i, wb_sel_i));
                    end else begin
                        next_s.rdat = {16'h0000, s.mask};
                    end
                end
                sasp_pkg::ADR_DATA: begin
                    // Accesses push or pop whole words, so no partial update
                    if (wb_we_i) begin
                        txPush = wb_sel_i[0] && !stat[sasp_pkg::ST_TBF];
                    end else begin
                        next_s.rdat = s.rxMem[s.rxRp];
                        rxPop = s.rxCnt != 6'h00;
                    end
                end
                sasp_pkg::ADR_ELM: begin
                    next_s.rdat[sasp_pkg::EL_TX +: 6] = s.txCnt;
                    next_s.rdat[sasp_pkg::EL_RX +: 6] = s.rxCnt;
                end
                default: begin
                    // Unmapped: acknowledged, reads zero
                end
            endcase
        end

        // Divider runs only while shifting
        next_s.divCnt = (tick || s.eng != sasp_pkg::ENG_SHIFT) ? 8'h00 : 8'(s.divCnt + 8'h01);

        unique case (s.eng)
            sasp_pkg::ENG_IDLE: begin
                next_s.sck = 1'b0;
                if (s.ctrl.mst && !pulse && !s.ctrl.aud) begin
                    next_s.ss = 1'b1;
                end
                if (s.ctrl.en) begin
                    if (s.ctrl.mst) begin
                        // Audio master never waits for data
                        start = s.ctrl.aud || s.txCnt != 6'h00;
                    end else if (s.ctrl.pins != sasp_pkg::PINS_4) begin
                        start = 1'b1;
                    end else if (s.ctrl.frm || s.ctrl.aud) begin
                        start = fsEdge;
                    end else begin
                        start = !s.ssS[1];
                    end
                end
            end
            sasp_pkg::ENG_SHIFT: begin
                if (doRise) begin
                    next_s.rxSr = {s.rxSr[30:0], s.sdiS[1]};
                    if (s.ctrl.mst) next_s.sck = 1'b1;
                end
                if (doFall) begin
                    if (s.ctrl.mst) next_s.sck = 1'b0;
                    if (s.ctrl.mst && pulse) next_s.ss = 1'b1;
                    if (s.bitCnt == len) begin
                        // Word complete: keep it unless receive is full
                        if (s.rxCnt == rxLim) begin
                            next_s.rov = 1'b1;
                        end else begin
                            rxPush = 1'b1;
                        end
                        next_s.eng = sasp_pkg::ENG_IDLE;
                    end else begin
                        next_s.bitCnt = 5'(s.bitCnt + 5'h01);
                        next_s.txSr = s.txSr << 1;
                        next_s.sdo = s.txSr[5'(len - 5'h01)];
                    end
                end
                // In framed or audio slave mode, a frame edge mid-word is a frame error
                if (!s.ctrl.mst && (s.ctrl.frm || s.ctrl.aud) && fsEdge && s.bitCnt != 5'h00) begin
                    next_s.ferr = 1'b1;
                end
            end
            sasp_pkg::ENG_HALT: begin
                // Stalled by an underrun until software clears it
                if (!s.tur || s.ctrl.ignore_underrun) next_s.eng = sasp_pkg::ENG_IDLE;
            end
        endcase

        // Word start: fetch data, or send zeros on underrun
        if (start) begin
            next_s.bitCnt = 5'h00;
            next_s.rxSr = 32'h0000_0000;
            next_s.eng = sasp_pkg::ENG_SHIFT;
            if (s.txCnt != 6'h00) begin
                txPop = 1'b1;
                next_s.txSr = s.txMem[s.txRp];
            end else begin
                under = 1'b1;
                next_s.txSr = 32'h0000_0000;
            end
            next_s.sdo = next_s.txSr[len];
            if (s.ctrl.ignore_underrun) begin
                next_s.tur = under;
            end else if (under) begin
                next_s.tur = 1'b1;
                next_s.eng = sasp_pkg::ENG_HALT;
            end
            if (s.ctrl.mst) begin
                // Channel clock toggles per word, else pulse low
                next_s.ss = (s.ctrl.aud && !pulse) ? !s.ss : 1'b0;
            end
        end

        // Buffer bookkeeping
        if (txPush) begin
            next_s.txMem[s.txWp] = wb_dat_i;
            next_s.txWp = 6'(s.txWp + 6'h01);
        end
        if (txPop) next_s.txRp = 6'(s.txRp + 6'h01);
        if (rxPush) begin
            next_s.rxMem[s.rxWp] = s.rxSr;
            next_s.rxWp = 6'(s.rxWp + 6'h01);
        end
        if (rxPop) next_s.rxRp = 6'(s.rxRp + 6'h01);
        next_s.txCnt = 6'(s.txCnt + {5'h00, txPush} - {5'h00, txPop});
        next_s.rxCnt = 6'(s.rxCnt + {5'h00, rxPush} - {5'h00, rxPop});

        // Disabled: errors and buffers cleared, engine idle
        if (!s.ctrl.en) begin
            next_s.tur = 1'b0;
            next_s.rov = 1'b0;
            next_s.ferr = 1'b0;
            next_s.eng = sasp_pkg::ENG_IDLE;
            next_s.txWp = 6'h00;
            next_s.txRp = 6'h00;
            next_s.txCnt = 6'h00;
            next_s.rxWp = 6'h00;
            next_s.rxRp = 6'h00;
            next_s.rxCnt = 6'h00;
        end
    end

    // ---------------------------------------------
    // State register
    // ---------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.ss <= sasp_pkg::SS_RST;
            // Select synchroniser starts at the idle level: no false edge
            s.ssS <= {2{sasp_pkg::SS_RST}};
            s.ssD <= sasp_pkg::SS_RST;
            s.eng <= sasp_pkg::ENG_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs; enables depend on role and pin count
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign serialDataOut = s.sdo;
    assign serialDataOutOe = s.ctrl.en && s.ctrl.pins != sasp_pkg::PINS_2;
    assign shiftClockOut = s.sck;
    assign shiftClockOe = s.ctrl.en && s.ctrl.mst;
    assign selectOut = s.ss;
    assign selectOe = s.ctrl.en && s.ctrl.mst && s.ctrl.pins == sasp_pkg::PINS_4;
    assign receiveIrqFlag = s.irq[0];
    assign transmitIrqFlag = s.irq[1];
    assign generalIrqFlag = s.irq[2];

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_SPARE_ZERO: assert property (req && !wb_we_i && wb_adr_i == sasp_pkg::ADR_STAT |=> wb_ack_o && !wb_dat_o[sasp_pkg::ST_SPARE]) else $error("spare status bit set");
    AST_TUR_OFF: assert property (!s.ctrl.en |=> !s.tur) else $error("underrun kept while disabled");
    AST_STD_FILL: assert property (s.ctrl.en && !s.ctrl.enh && s.txCnt == 6'h00 && !start && req && wb_we_i && wb_adr_i == sasp_pkg::ADR_DATA && wb_sel_i[0] |=> stat[sasp_pkg::ST_TBF] && !stat[sasp_pkg::ST_TBE]) else $error("standard write did not fill");
    AST_TBE_SET: assert property (!s.ctrl.enh && txPop |=> stat[sasp_pkg::ST_TBE]) else $error("empty not set on move");
    AST_RBF_CLR: assert property (s.ctrl.en && !s.ctrl.enh && rxPop && !rxPush |=> !stat[sasp_pkg::ST_RBF]) else $error("receive full not cleared");
    AST_RX_IRQ: assert property ((stat & s.mask & sasp_pkg::RX_GRP) != 16'h0000 |=> receiveIrqFlag) else $error("receive flag missing");
    AST_TX_IRQ: assert property ((stat & s.mask & sasp_pkg::TX_GRP) == 16'h0000 |=> !transmitIrqFlag) else $error("spurious transmit flag");
    AST_GEN_IRQ: assert property ($rose(s.ferr) && s.mask[sasp_pkg::ST_FERR] |=> generalIrqFlag) else $error("general flag missing");
    AST_TWO_PIN: assert property (s.ctrl.pins == sasp_pkg::PINS_2 |-> !serialDataOutOe && !selectOe) else $error("unused pin driven");
    AST_AUD_RUN: assert property (s.ctrl.en && s.ctrl.mst && s.ctrl.aud && s.eng == sasp_pkg::ENG_IDLE |=> s.eng != sasp_pkg::ENG_IDLE) else $error("audio master waited");
    AST_LIVE_TUR: assert property (s.ctrl.en && s.ctrl.ignore_underrun && start |=> s.eng == sasp_pkg::ENG_SHIFT && s.tur == $past(under)) else $error("ignored underrun halted");
    AST_DIV_TOGGLE: assert property (s.ctrl.en && s.ctrl.mst && s.eng == sasp_pkg::ENG_SHIFT && tick |=> s.sck != $past(s.sck)) else $error("master clock stuck");

    COV_AUDIO_WORD: cover property (s.ctrl.aud && rxPush);
    COV_OVERFLOW: cover property ($rose(s.rov));
    COV_FRAME_ERR: cover property ($rose(s.ferr));
    COV_ENH_FULL: cover property (s.ctrl.enh && stat[sasp_pkg::ST_TBF]);

endmodule
`default_nettype wire

// *** testbench/sasp_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// Slave peer on the far side of the serial pins
// ---------------------------------------------
module sasp_peer (
    input wire logic shiftClock,
    input wire logic selectN,
    input wire logic fromDev,
    output logic toDev,
    input wire logic [4:0] len,
    input wire logic [31:0] txWord,
    output logic [31:0] rxWord,
    output logic [5:0] rxBits
);
    logic [4:0] idx; // Index of the bit now on the line

    initial begin
        toDev = 1'b0;
        rxWord = 32'h00000000;
        rxBits = 6'h00;
        idx = 5'h00;
    end

    // Select falling opens a frame; top bit goes out before the first rise
    always @(negedge selectN) begin
        idx = len;
        rxWord = 32'h00000000;
        rxBits = 6'h00;
        toDev = txWord[len];
    end

    // Sample on the rising shift clock, most significant bit first
    always @(posedge shiftClock) begin
        if (!selectN) begin
            rxWord = {rxWord[30:0], fromDev};
            rxBits = rxBits + 6'h01;
        end
    end

    // Next bit on the falling edge, as the device expects
    always @(negedge shiftClock) begin
        if (!selectN && idx != 5'h00) begin
            idx = idx - 5'h01;
            toDev = txWord[idx];
        end
    end

    // Released line has no pull, so it must not keep the last bit
    always @(posedge selectN) begin
        toDev = ~toDev;
    end
endmodule
`default_nettype wire

// *** testbench/test_sasp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_sasp_top;
    // ---------------------------------------------
    // Clock, bus and pin signals
    // ---------------------------------------------
    logic mclk = 1'b0; // 125 MHz system clock
    logic rst = 1'b1; // Held for 12 cycles
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF; // Full words only
    logic [31:0] wdat = 32'h00000000, datO, rdv, seed = 32'h0000001F, pTx = 32'h00000000, pRx;
    logic ack, sdo, sdoOe, sdi, sckO, sckOe, selO, selOe, rxIrq, txIrq, genIrq, pSck, pSel;
    logic linkClk = 1'b0, linkSel = 1'b1; // Link clock stands still outside frames
    logic [4:0] pLen = 5'h07;
    logic [5:0] pBits;
    logic sckPrev = 1'b0, selPrev = 1'b1;
    int errTotal = 0, checked = 0, sckEdges = 0, selEdges = 0, i, f;
    typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} sasp_note_s;
    sasp_note_s notes[$]; // Expected read results, oldest first
    sasp_note_s n;

    // Pin level is whoever drives it: the device when its output enable is set, else the bench
    assign pSck = sckOe ? sckO : linkClk;
    assign pSel = selOe ? selO : linkSel;

    always #4 mclk = ~mclk;

    sasp_top u_sasp_top (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
        .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOutOe(sdoOe), .shiftClockIn(pSck),
        .shiftClockOut(sckO), .shiftClockOe(sckOe), .selectIn(pSel), .selectOut(selO),
        .selectOe(selOe), .receiveIrqFlag(rxIrq), .transmitIrqFlag(txIrq), .generalIrqFlag(genIrq));

    sasp_peer u_sasp_peer (.shiftClock(pSck), .selectN(pSel), .fromDev(sdo), .toDev(sdi),
        .len(pLen), .txWord(pTx), .rxWord(pRx), .rxBits(pBits));

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic printVerdict();
        $display("checked %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Classic single cycle: hold everything until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 100);
        rdv = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 100) begin
            check("bus ack", 32'h0, 32'h1);
        end
    endtask

    // A read notes what it expects; the monitor compares when the data shows
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{nm, e, m});
        wb(1'b0, a, 32'h00000000);
    endtask

    task automatic cfg(input logic en, mst, enh, aud, input logic [1:0] fmt, pins, input logic ign,
        input logic [4:0] len);
        sasp_pkg::sasp_ctrl_s c;
        // Half period of three cycles leaves room for the data-in synchroniser
        c = '{div:8'h02, len:len, ignore_underrun:ign, pins:pins, fmt:fmt, aud:aud, frm:1'b0, enh:enh, mst:mst, en:en};
        wb(1'b1, sasp_pkg::ADR_CTRL, {9'h000, c});
    endtask

    // Poll until a received word is waiting; the poll itself checks nothing
    task automatic waitRx();
        int k;
        k = 0;
        do begin
            rd("poll", sasp_pkg::ADR_STAT, 32'h0, 32'h0);
            k++;
        end while (rdv[0] !== 1'b1 && k < 300);
    endtask

    // One word each way with the device as master; length is bits minus one
    task automatic mxfer(input logic [4:0] len);
        logic [31:0] m;
        logic [31:0] d;
        m = 32'hFFFFFFFF >> (5'h1F - len);
        seed = lfsr(seed);
        pTx = seed;
        pLen = len;
        seed = lfsr(seed);
        d = seed;
        cfg(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, sasp_pkg::PINS_4, 1'b0, len);
        wb(1'b1, sasp_pkg::ADR_DATA, d);
        waitRx();
        rd("status after word", sasp_pkg::ADR_STAT, 32'h09, 32'h1F);
        rd("rx word", sasp_pkg::ADR_DATA, pTx & m, 32'hFFFFFFFF);
        check("peer word", pRx & m, d & m);
        check("peer bits", pBits, {27'h0, len} + 32'h1);
        rd("rx drained", sasp_pkg::ADR_STAT, 32'h0, 32'h01);
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, sasp_pkg::PINS_4, 1'b0, len);
    endtask

    // ---------------------------------------------
    // Monitor: every read answer takes the oldest note
    // ---------------------------------------------
    always @(posedge mclk) begin
        sckPrev <= sckO;
        selPrev <= selO;
        if (sckO !== sckPrev) sckEdges++;
        if (selO !== selPrev) selEdges++;
        if (ack === 1'b1 && we === 1'b0) begin
            if (notes.size() == 0) begin
                check("unexpected read", 32'h0, 32'h1);
            end else begin
                n = notes.pop_front();
                check(n.nm, datO & n.msk, n.exp & n.msk);
            end
        end
    end

    // Watchdog: far beyond the roughly 1500 cycles the sequence needs
    initial begin
        repeat (40000) @(posedge mclk);
        errTotal++;
        printVerdict();
    end

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd("reset status", sasp_pkg::ADR_STAT, 32'h18, 32'h1F);
        rd("unmapped", 8'h14, 32'h0, 32'hFFFFFFFF);
        // Masked conditions while idle: tx empty, rx empty, shifter empty
        for (i = 0; i < 3; i++) begin
            wb(1'b1, sasp_pkg::ADR_MASK, 32'h8 << i);
            repeat (3) @(posedge mclk);
            check("irq flags", {genIrq, txIrq, rxIrq}, (i == 0) ? 3'h2 : (i == 1) ? 3'h1 : 3'h4);
        end
        wb(1'b1, sasp_pkg::ADR_MASK, 32'h0);
        // Pin usage per wiring choice, master so the device drives
        for (i = 0; i < 3; i++) begin
            cfg(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 2'(i), 1'b0, 5'h07);
            repeat (2) @(posedge mclk);
            check("select drive", selOe, i == 0);
            check("data drive", sdoOe, i != 2);
            check("clock drive", sckOe, 1'b1);
        end
        // Deep buffer as slave with select idle: fill, refuse the 64th, clear
        cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, sasp_pkg::PINS_4, 1'b0, 5'h07);
        for (i = 0; i < 64; i++) wb(1'b1, sasp_pkg::ADR_DATA, 32'(i));
        rd("tx elements", sasp_pkg::ADR_ELM, 32'h3F, 32'h3F);
        rd("fifo full", sasp_pkg::ADR_STAT, 32'h02, 32'h0A);
        cfg(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, sasp_pkg::PINS_4, 1'b0, 5'h07);
        rd("fifo empty", sasp_pkg::ADR_STAT, 32'h08, 32'h0A);
        // Master words at eight bits, then shortest and longest length
        mxfer(5'h07);
        mxfer(5'h01);
        mxfer(5'h1F);
        // Slave word clocked by the bench at 160 ns, edges on mclk rising edges
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, sasp_pkg::PINS_4, 1'b0, 5'h07);
        seed = lfsr(seed);
        pTx = seed;
        pLen = 5'h07;
        wb(1'b1, sasp_pkg::ADR_DATA, ~seed);
        rd("tx loaded", sasp_pkg::ADR_STAT, 32'h02, 32'h0E);
        linkSel <= 1'b0;
        repeat (8) begin
            repeat (10) @(posedge mclk);
            linkClk <= 1'b1;
            repeat (10) @(posedge mclk);
            linkClk <= 1'b0;
        end
        // Select rises with the last fall, so no second word starts
        linkSel <= 1'b1;
        waitRx();
        rd("slave rx word", sasp_pkg::ADR_DATA, pTx & 32'hFF, 32'hFFFFFFFF);
        check("slave tx word", pRx & 32'hFF, ~seed & 32'hFF);
        check("slave bits", pBits, 32'h8);
        // Every audio format runs with no data and flags underrun
        for (f = 0; f < 4; f++) begin
            cfg(1'b1, 1'b1, 1'b0, 1'b1, 2'(f), sasp_pkg::PINS_4, 1'b0, 5'h07);
            repeat (100) @(posedge mclk);
            rd("underrun", sasp_pkg::ADR_STAT, 32'h80, 32'h80);
            cfg(1'b0, 1'b1, 1'b0, 1'b1, 2'(f), sasp_pkg::PINS_4, 1'b0, 5'h07);
            rd("underrun cleared", sasp_pkg::ADR_STAT, 32'h0, 32'h80);
        end
        // Ignoring underrun must leave both clocks running
        cfg(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, sasp_pkg::PINS_4, 1'b1, 5'h07);
        sckEdges = 0;
        selEdges = 0;
        repeat (300) @(posedge mclk);
        check("shift clock runs", sckEdges > 40, 32'h1);
        check("channel clock runs", selEdges > 2, 32'h1);
        repeat (4) @(posedge mclk);
        printVerdict();
    end
endmodule
`default_nettype wire
